// ---- verilog/ers_pkg.sv ----
/*
  Constants and carrier types for the enclosure request signalling front end.
  Assumes a single 125 MHz clock and a synchronous active-high reset.
*/
package ers_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 8;
  localparam int SEL_SETTLE_NS  = 7000;
  localparam int SEL_SETTLE_CYC = (SEL_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W          = 10;

  // ----------------------------------------------------------------
  // Location identifier
  // ----------------------------------------------------------------
  localparam int         LOC_W       = 7;
  localparam logic [6:0] LOC_SOFT    = 7'h7f;
  localparam logic [6:0] LOC_FABRIC  = 7'h7e;
  localparam logic [6:0] LOC_RESET   = 7'h00;
  localparam int         WR_BIT      = 6;
  localparam int         RD_BIT      = 5;
  localparam int         NIB_W       = 4;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ERS_REQ_LOC,
    ERS_REQ_LEGACY,
    ERS_REQ_READ,
    ERS_REQ_WRITE
  } ers_req_e;

  typedef struct packed {
    logic [6:0] loop_id;
    logic       soft_addr;
    logic       fabric_rsvd;
  } ers_loc_s;

  typedef struct packed {
    logic [6:0] o;
    logic [6:0] oe_n;
  } ers_sel_drv_s;

endpackage

// ---- verilog/ers_front.sv ----
/*
  Device-side enclosure request front end: drives the request line, samples
  location ID lines, and runs the nibble strobe phase of block transfers.
  Assumes the backplane pulls the request line high and answers on the ID pins.
*/
// Rules from the document
// [R1] Dash-named signals are active low; others active high.
// [R2] Receivers decode only the level, whether driven or pulled.
// [R3] Device drives the request line to ask for location ID lines.
// [R4] Same request line asks for legacy status or block read/write.
// [R5] The request output is always implemented.
// [R6] Backplane holds the request line negated until device drives it.
// [R7] On older backplane, asserting request returns legacy status lines.
// [R8] Discovery decides older versus bidirectional backplane and acts accordingly.
// [R9] Enclosure sends null status to devices failing discovery.
// [R10] Upper ID pins double as strobes, lower four as data; tri-state otherwise.
// [R11] ID lines valid within 7 us after request negation.
// [R12] Seven ID lines read as binary, high is one, line 6 is MSB.
// [R13] ID 127 means soft address; 126 is reserved for fabric.
module ers_front (
  input  wire logic                 clk,
  input  wire logic                 srst,
  input  wire logic                 ce,
  input  wire logic                 req_valid,
  input  wire ers_pkg::ers_req_e    req_kind,
  input  wire logic [3:0]           wr_nibble,
  output logic                      req_ready,
  output logic                      done,
  output logic [3:0]                rd_nibble,
  output logic                      legacy_bp_q,
  output ers_pkg::ers_loc_s         loc_q,
  output logic                      enclosure_request_n_o,
  output logic                      enclosure_request_n_oe_n,
  input  wire logic [6:0]           sel_i,
  output ers_pkg::ers_sel_drv_s     sel_drv
);

  typedef enum logic [1:0] {ST_IDLE, ST_ASSERT, ST_STROBE, ST_RELEASE} ers_st_e;

  // Two extra cycles cover the pin synchroniser
  localparam logic [ers_pkg::CNT_W-1:0] SETTLE_END =
    ers_pkg::CNT_W'(ers_pkg::SEL_SETTLE_CYC + 2);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [6:0] sel_m_q;
  logic [6:0] sel_s_q;
  logic       req_m_q;
  logic       req_s_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      sel_m_q <= '0;
      sel_s_q <= '0;
      req_m_q <= 1'b1;
      req_s_q <= 1'b1;
    end else if (ce) begin
      sel_m_q <= sel_i;
      sel_s_q <= sel_m_q;
      req_m_q <= enclosure_request_n_o | enclosure_request_n_oe_n;
      req_s_q <= req_m_q;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  ers_st_e                              st_q;
  ers_pkg::ers_req_e                    kind_q;
  logic [ers_pkg::CNT_W-1:0]            cnt_q;
  logic [3:0]                           wdat_q;
  logic                                 drive_req;

  assign req_ready = (st_q == ST_IDLE);
  assign drive_req = (st_q == ST_ASSERT) || (st_q == ST_STROBE);

  always_ff @(posedge clk) begin
    if (srst) begin
      st_q   <= ST_IDLE;
      kind_q <= ers_pkg::ERS_REQ_LOC;
      cnt_q  <= '0;
      wdat_q <= '0;
    end else if (ce) begin
      unique case (st_q)
        ST_IDLE: begin
          if (req_valid) begin
            kind_q <= req_kind;                              // R4
            wdat_q <= wr_nibble;
            cnt_q  <= '0;
            st_q   <= ST_ASSERT;                             // R3
          end
        end
        ST_ASSERT: begin
          if (!req_s_q) begin                                // R2
            st_q  <= (kind_q == ers_pkg::ERS_REQ_READ || kind_q == ers_pkg::ERS_REQ_WRITE)
                     && !legacy_bp_q ? ST_STROBE : ST_RELEASE;
            cnt_q <= '0;
          end
        end
        ST_STROBE: begin
          st_q  <= ST_RELEASE;
          cnt_q <= '0;
        end
        ST_RELEASE: begin
          if (cnt_q == SETTLE_END) begin                     // R11
            st_q <= ST_IDLE;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Request pin and shared ID pins
  // ----------------------------------------------------------------
  always_comb begin
    enclosure_request_n_o    = 1'b0;                         // R5
    enclosure_request_n_oe_n = !drive_req;                   // R1 R6
    sel_drv.o                = '0;
    sel_drv.oe_n             = '1;                           // R10
    if (st_q == ST_STROBE && !legacy_bp_q) begin             // R8
      if (kind_q == ers_pkg::ERS_REQ_WRITE) begin
        sel_drv.o[ers_pkg::WR_BIT]             = 1'b0;
        sel_drv.oe_n[ers_pkg::WR_BIT]          = 1'b0;
        sel_drv.o[ers_pkg::NIB_W-1:0]          = wdat_q;     // R10
        sel_drv.oe_n[ers_pkg::NIB_W-1:0]       = '0;
      end else begin
        sel_drv.o[ers_pkg::RD_BIT]             = 1'b0;
        sel_drv.oe_n[ers_pkg::RD_BIT]          = 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Results
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      done        <= 1'b0;
      rd_nibble   <= '0;
      legacy_bp_q <= 1'b0;
      loc_q       <= '{ers_pkg::LOC_RESET, 1'b0, 1'b0};
    end else if (ce) begin
      done <= (st_q == ST_RELEASE) &&
              (cnt_q == SETTLE_END);
      if (st_q == ST_STROBE && kind_q == ers_pkg::ERS_REQ_READ) begin
        rd_nibble <= sel_s_q[ers_pkg::NIB_W-1:0];
      end
      // Discovery: status lines read while the request is held low; a nibble
      // other than all ones marks an older backplane
      if (st_q == ST_ASSERT && !req_s_q && kind_q == ers_pkg::ERS_REQ_LEGACY) begin
        legacy_bp_q <= (sel_s_q[ers_pkg::NIB_W-1:0] != '1);          // R7 R8
      end
      if (st_q == ST_RELEASE && cnt_q == SETTLE_END) begin
        if (kind_q == ers_pkg::ERS_REQ_LOC) begin
          loc_q.loop_id     <= sel_s_q;                                // R12
          loc_q.soft_addr   <= (sel_s_q == ers_pkg::LOC_SOFT);         // R13
          loc_q.fabric_rsvd <= (sel_s_q == ers_pkg::LOC_FABRIC);       // R13
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence req_driven_s;
    !enclosure_request_n_oe_n && !enclosure_request_n_o;
  endsequence

  req_start_a: assert property (@(posedge clk) disable iff (srst) // R3
    ce && req_ready && req_valid |=> req_driven_s)
    else $error("Request line not driven after request taken");

  idle_release_a: assert property (@(posedge clk) disable iff (srst) // R6
    req_ready |-> enclosure_request_n_oe_n)
    else $error("Request line driven while idle");

  pins_tri_a: assert property (@(posedge clk) disable iff (srst) // R10
    st_q != ST_STROBE |-> sel_drv.oe_n == 7'h7f)
    else $error("ID pins driven outside strobe phase");

  wr_strobe_a: assert property (@(posedge clk) disable iff (srst) // R10
    st_q == ST_STROBE && kind_q == ers_pkg::ERS_REQ_WRITE && !legacy_bp_q
    |-> !sel_drv.oe_n[ers_pkg::WR_BIT] && sel_drv.oe_n[ers_pkg::RD_BIT])
    else $error("Write strobe not alone on strobe pins");

  soft_flag_a: assert property (@(posedge clk) disable iff (srst) // R13
    loc_q.soft_addr == (loc_q.loop_id == ers_pkg::LOC_SOFT))
    else $error("Soft address flag mismatch");

  legacy_nostrobe_a: assert property (@(posedge clk) disable iff (srst) // R8
    legacy_bp_q |-> sel_drv.oe_n == 7'h7f)
    else $error("Strobes driven on older backplane");

  settle_wait_a: assert property (@(posedge clk) disable iff (srst) // R11
    ce && $rose(st_q == ST_RELEASE) |-> !done [*8])
    else $error("Done raised before settle time");

  sequence strobe_then_release_s;
    st_q == ST_STROBE ##1 st_q == ST_RELEASE;
  endsequence

  assert_hold_a: assert property (@(posedge clk) disable iff (srst) // R3
    st_q == ST_ASSERT |-> req_driven_s)
    else $error("Request line released before it read low");

  strobe_once_a: assert property (@(posedge clk) disable iff (srst) // R10
    ce && st_q == ST_STROBE |-> strobe_then_release_s)
    else $error("Strobe phase longer than one cycle");

  rd_strobe_a: assert property (@(posedge clk) disable iff (srst) // R10
    st_q == ST_STROBE && kind_q == ers_pkg::ERS_REQ_READ && !legacy_bp_q
    |-> !sel_drv.oe_n[ers_pkg::RD_BIT] && sel_drv.oe_n[ers_pkg::WR_BIT]
        && sel_drv.oe_n[ers_pkg::NIB_W-1:0] == 4'hf)
    else $error("Read strobe not alone or data pins driven");

  settle_free_a: assert property (@(posedge clk) disable iff (srst) // R11
    st_q == ST_RELEASE |-> enclosure_request_n_oe_n)
    else $error("Request line driven during settle time");

  done_pulse_a: assert property (@(posedge clk) disable iff (srst) // R11
    ce && done |=> !done)
    else $error("Done longer than one cycle");

endmodule

// ---- tb/ers_bp_model.sv ----
/*
  Behavioural backplane for the enclosure request front end.
  Assumes device pin drive wins over this model on every shared pin.
*/
module ers_bp_model (
  input  wire logic                  clk,
  input  wire logic                  req_oe_n,
  input  wire ers_pkg::ers_sel_drv_s sel_drv,
  input  wire logic [6:0]            loc_id,
  input  wire logic [3:0]            nib,
  output logic [6:0]                 sel_i,
  output logic [3:0]                 wr_seen,
  output int                         n_req
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Pin levels
  // ----------------------------------------------------------------
  logic       req_pin;
  logic       req_pin_q;
  logic [6:0] bp;
  logic [6:0] last;
  int         settle;
  assign req_pin = req_oe_n ? 1'b1 : 1'b0;
  always_comb begin
    if (!req_pin) begin
      bp = {3'b111, nib};
    end else if (settle >= ers_pkg::SEL_SETTLE_CYC) begin
      bp = loc_id;
    end else begin
      bp = ~last;
    end
  end
  for (genvar k = 0; k < 7; k++) begin : g_pin
    assign sel_i[k] = sel_drv.oe_n[k] ? bp[k] : sel_drv.o[k];
  end
  initial begin
    settle = 0;
    last = 7'h00;
    n_req = 0;
    wr_seen = 4'h0;
    req_pin_q = 1'b1;
  end
  always @(posedge clk) begin
    last <= bp;
    req_pin_q <= req_pin;
    settle <= req_pin ? settle + 1 : 0;
    if (req_pin_q && !req_pin) n_req <= n_req + 1;
    if (!req_pin && !sel_i[6]) wr_seen <= sel_i[3:0];
  end
endmodule

// ---- tb/test_ers_front.sv ----
/*
  Self-checking bench for the enclosure request front end.
  Assumes the design answers within about 900 cycles of each request.
*/
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin \
  $display("MISMATCH %s exp %h got %h", nm, ex, got); err_total++; end end
module test_ers_front;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, srst, ce, req_valid, req_ready, done, legacy_bp_q, rq_o, rq_oe_n;
  logic                  exp_lg;
  logic [3:0]            exp_rd, exp_wr;
  ers_pkg::ers_req_e     req_kind;
  logic [3:0]            wr_nibble, rd_nibble, wr_seen, nib;
  logic [6:0]            sel_i, loc_id;
  ers_pkg::ers_loc_s     loc_q;
  ers_pkg::ers_sel_drv_s sel_drv;
  int err_total, n_compared, n_req, cyc, seed, lat, exp_id;
  ers_front dut_u (.clk(clk), .srst(srst), .ce(ce), .req_valid(req_valid),
    .req_kind(req_kind), .wr_nibble(wr_nibble), .req_ready(req_ready), .done(done),
    .rd_nibble(rd_nibble), .legacy_bp_q(legacy_bp_q), .loc_q(loc_q),
    .enclosure_request_n_o(rq_o), .enclosure_request_n_oe_n(rq_oe_n),
    .sel_i(sel_i), .sel_drv(sel_drv));
  ers_bp_model bp_u (.clk(clk), .req_oe_n(rq_oe_n), .sel_drv(sel_drv),
    .loc_id(loc_id), .nib(nib), .sel_i(sel_i), .wr_seen(wr_seen), .n_req(n_req));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_total++;
      report_and_stop();
    end
  end
  // One request, then compare against the bench's own model of the results
  task automatic do_req(input logic [1:0] k, input logic [6:0] id, input logic [3:0] n,
                        input int frz);
    int nr;
    logic saw;
    nr = n_req;
    saw = 1'b0;
    if (k == 2'd0) exp_id = id;
    if (k == 2'd1) exp_lg = (n != 4'hf);
    if (k == 2'd2 && !exp_lg) exp_rd = n;
    if (k == 2'd3 && !exp_lg) exp_wr = ~n;
    @(negedge clk);
    loc_id = id;
    nib = n;
    req_kind = ers_pkg::ers_req_e'(k);
    wr_nibble = ~n;
    req_valid = 1'b1;
    `CHK("ready", 1'b1, req_ready)
    @(negedge clk);
    req_valid = 1'b0;
    lat = 1;
    while (done !== 1'b1 && lat < 2000) begin
      @(negedge clk);
      lat++;
      if (lat == 100 && frz > 0) begin
        ce = 1'b0;
        repeat (frz) begin
          @(negedge clk);
          if (done !== 1'b0) saw = 1'b1;
        end
        ce = 1'b1;
        lat += frz;
      end
    end
    `CHK("frozen", 1'b0, saw)
    `CHK("latency_ok", 1'b1, lat >= 875 + frz && lat < 2000)
    `CHK("req_count", nr + 1, n_req)
    `CHK("loop_id", exp_id[6:0], loc_q.loop_id)
    `CHK("soft", exp_id == 127, loc_q.soft_addr)
    `CHK("fabric", exp_id == 126, loc_q.fabric_rsvd)
    `CHK("legacy", exp_lg, legacy_bp_q)
    `CHK("rd_nib", exp_rd, rd_nibble)
    `CHK("wr_nib", exp_wr, wr_seen)
    `CHK("req_released", 1'b1, rq_oe_n)
    `CHK("req_level", 1'b0, rq_o)
  endtask
  initial begin
    logic [6:0] ids[4];
    seed = 32'h9eed;
    {err_total, n_compared, cyc} = '0;
    {req_valid, wr_nibble, loc_id, nib} = '0;
    req_kind = ers_pkg::ERS_REQ_LOC;
    ce = 1'b1;
    exp_id = 0;
    exp_lg = 1'b0;
    exp_rd = 4'h0;
    exp_wr = 4'h0;
    srst = 1'b1;
    repeat (3) @(negedge clk);
    srst = 1'b0;
    `CHK("rst_oe", 1'b1, rq_oe_n)
    ids = '{7'h7f, 7'h7e, 7'h00, 7'h2a};
    for (int i = 0; i < 24; i++) begin
      do_req(i[1:0], (i < 16) ? ids[i >> 2] : 7'($random(seed)),
             (i[1:0] == 2'd1) ? 4'hf : 4'($random(seed)), 0);
      $display("test %0d finished", i);
    end
    do_req(2'd0, 7'h33, 4'h0, 900);
    $display("test freeze finished");
    do_req(2'd1, 7'h15, 4'h5, 0);
    do_req(2'd3, 7'h15, 4'h9, 0);
    do_req(2'd2, 7'h15, 4'h6, 0);
    $display("test legacy finished");
    @(negedge clk);
    srst = 1'b1;
    repeat (3) @(negedge clk);
    srst = 1'b0;
    exp_id = 0;
    exp_lg = 1'b0;
    exp_rd = 4'h0;
    `CHK("rst_legacy", 1'b0, legacy_bp_q)
    `CHK("rst_loc", 7'h00, loc_q.loop_id)
    `CHK("rst_rd", 4'h0, rd_nibble)
    do_req(2'd2, 7'h40, 4'h3, 0);
    $display("test reset finished");
    report_and_stop();
  end
endmodule
